// ---- rtl/p3irq_top.sv ----
/*
 * Port 3 interrupt sources: pin synchronisers, edge detection, six
 * pending flags, comparator steering and vector address output.
 * Assumes the core writes the pending register by a write strobe and
 * acknowledges a granted source with a one-hot pulse.
 */
`timescale 1ns/100ps
`default_nettype none
module p3irq_top (
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_ARST_N,
    input  wire logic [3:0] I_PORT3_IN,      // lines 0..3 pins
    input  wire logic       I_CMP_A_RESULT,  // comparator a result
    input  wire logic       I_CMP_B_RESULT,  // comparator b result
    input  wire logic       I_TIMER_ZERO_EV, // internal, same clock
    input  wire logic       I_TIMER_ONE_EV,  // internal, same clock
    input  wire logic       I_TIMER_ONE_OUT, // timer one output level
    input  wire logic [1:0] I_HS_OUT,        // handshake outputs lines 4/5
    input  wire logic [7:0] I_MODE_REG,      // port3_mode_reg
    input  wire logic [7:0] I_CONFIG_REG,    // port_config_reg
    input  wire logic       I_PEND_WR,
    input  wire logic [7:0] I_PEND_WDATA,
    input  wire logic [5:0] I_ACK,
    input  wire logic [2:0] I_VEC_SEL,       // source to vector
    output logic      [7:0] O_PEND_REG,
    output logic      [3:0] O_PORT3_RD,      // synchronised input levels
    output logic            O_TIMER_ONE_IN,
    output logic      [3:0] O_HS_IN,         // handshake inputs lines 1..3, 0
    output logic      [3:0] O_PORT3_OUT,     // lines 4,5,6,7
    output logic      [5:0] O_IRQ,
    output logic     [11:0] O_VEC_ADDR,
    output logic            O_CMP_VALID
);
    // ---------------------------------------------------------------
    // synchronisers: three stages, change once stages 2 and 3 agree
    // ---------------------------------------------------------------
    logic [3:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
    logic       ca1_q, ca2_q, ca3_q, cb1_q, cb2_q, cb3_q, cal_q, cbl_q, cal_d, cbl_d;
    // filtered level only moves when stages two and three match
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < 4; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
        cal_d = (ca2_q == ca3_q) ? ca3_q : cal_q;
        cbl_d = (cb2_q == cb3_q) ? cb3_q : cbl_q;
    end
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            {s1_q, s2_q, s3_q, lvl_q} <= 16'hFFFF;
            {ca1_q, ca2_q, ca3_q, cal_q} <= 4'h0;
            {cb1_q, cb2_q, cb3_q, cbl_q} <= 4'h0;
        end else begin
            s1_q  <= I_PORT3_IN;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
            ca1_q <= I_CMP_A_RESULT;
            ca2_q <= ca1_q;
            ca3_q <= ca2_q;
            cal_q <= cal_d;
            cb1_q <= I_CMP_B_RESULT;
            cb2_q <= cb1_q;
            cb3_q <= cb2_q;
            cbl_q <= cbl_d;
        end
    end

    // ---------------------------------------------------------------
    // source selection and edge qualification
    // ---------------------------------------------------------------
    logic       analog;
    logic [1:0] edge_mode;
    logic       src0_q, src1_q, src2_q, src3_q;
    logic       src0, src1, src2, src3;
    logic [5:0] hit;
    logic [7:0] pend_q, pend_d;
    logic [2:0] warm_q, warm_d;
    logic       live;
    // a pin held low through reset would look like a falling edge while the
    // synchronisers fill, so edge detection waits until they hold real levels
    assign live = (warm_q == 3'(p3irq_pkg::WARM_CYC));
    always_comb begin
        warm_d = warm_q;
        if (!live) begin
            warm_d = warm_q + 3'h1;
        end
    end
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            warm_q <= 3'h0;
        end else begin
            warm_q <= warm_d;
        end
    end
    assign analog    = I_MODE_REG[p3irq_pkg::ANALOG_BIT]; // R16
    assign edge_mode = pend_q[p3irq_pkg::EDGE_HI_BIT:p3irq_pkg::EDGE_LO_BIT]; // R1
    // analog mode swaps line 1/2 for comparator results; line 3 is reference
    assign src0 = analog ? cbl_q : lvl_q[2]; // R12 R14 R3
    assign src1 = lvl_q[3]; // R4 R12
    assign src2 = analog ? cal_q : lvl_q[1]; // R12 R14 R3
    assign src3 = lvl_q[0]; // R12
    // line1 drives source2 (edge hi bit), line2 drives source0 (lo bit)
    always_comb begin
        hit[1] = src1_q & ~src1; // R2
        hit[3] = src3_q & ~src3; // R2
        hit[4] = I_TIMER_ZERO_EV;
        hit[5] = I_TIMER_ONE_EV;
        case (edge_mode) // R13
            2'b00: begin
                hit[2] = src2_q & ~src2;
                hit[0] = src0_q & ~src0;
            end
            2'b01: begin
                hit[2] = src2_q & ~src2;
                hit[0] = ~src0_q & src0;
            end
            2'b10: begin
                hit[2] = ~src2_q & src2;
                hit[0] = src0_q & ~src0;
            end
            default: begin
                hit[2] = src2_q ^ src2;
                hit[0] = src0_q ^ src0;
            end
        endcase
        if (!live) begin
            hit[3:0] = 4'h0; // R17
        end
    end
    // pending flags: an event in the clearing cycle still sets the flag
    always_comb begin
        pend_d = pend_q;
        if (I_PEND_WR) begin
            pend_d = I_PEND_WDATA;
        end
        pend_d[5:0] = (pend_d[5:0] & ~I_ACK) | hit; // R17
    end
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pend_q <= p3irq_pkg::PEND_RST;
            {src0_q, src1_q, src2_q, src3_q} <= 4'hF;
        end else begin
            pend_q <= pend_d;
            src0_q <= src0;
            src1_q <= src1;
            src2_q <= src2;
            src3_q <= src3;
        end
    end

    // ---------------------------------------------------------------
    // comparator settle counter after analog enable
    // ---------------------------------------------------------------
    logic [7:0] settle_q, settle_d;
    logic       analog_q;
    // software must still wait; this only flags validity for status
    always_comb begin
        settle_d = settle_q;
        if (!analog) begin
            settle_d = 8'h00;
        end else if (!analog_q) begin
            settle_d = 8'(p3irq_pkg::SETTLE_CYC); // R6
        end else if (settle_q != 8'h00) begin
            settle_d = settle_q - 8'h01;
        end
    end
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            settle_q <= 8'h00;
            analog_q <= 1'b0;
        end else begin
            settle_q <= settle_d;
            analog_q <= analog;
        end
    end

    // ---------------------------------------------------------------
    // registered outputs: pins, vectors, status
    // ---------------------------------------------------------------
    logic [3:0]  out_d;
    logic [11:0] vec_d;
    // comparator routing overrides handshake output 0 on line 4 and the constant 0 on line 7
    always_comb begin
        out_d[0] = I_HS_OUT[0];
        out_d[1] = I_HS_OUT[1]; // R9
        out_d[2] = I_TIMER_ONE_OUT; // R8
        out_d[3] = 1'b0;
        if (I_CONFIG_REG[p3irq_pkg::CMP_OUT_BIT]) begin // R5
            out_d[0] = cal_q;
            out_d[3] = cbl_q;
        end
        // vector pair base; core fetches 16-bit address at this and next
        if (I_VEC_SEL < 3'(p3irq_pkg::NUM_SRC)) begin
            vec_d = {8'h00, I_VEC_SEL, 1'b0}; // R11 R15
        end else begin
            vec_d = p3irq_pkg::ROM_FIRST_ADDR; // R10
        end
    end
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_PEND_REG     <= p3irq_pkg::PEND_RST;
            O_PORT3_RD     <= 4'hF;
            O_TIMER_ONE_IN <= 1'b1;
            O_HS_IN        <= 4'hF;
            O_PORT3_OUT    <= 4'h0;
            O_IRQ          <= 6'h00;
            O_VEC_ADDR     <= 12'h000;
            O_CMP_VALID    <= 1'b0;
        end else begin
            O_PEND_REG     <= pend_d;
            O_PORT3_RD     <= lvl_q; // R4
            O_TIMER_ONE_IN <= lvl_q[1]; // R8
            O_HS_IN        <= {lvl_q[0], lvl_q[3:1]}; // R9
            O_PORT3_OUT    <= out_d;
            O_IRQ          <= pend_d[5:0];
            O_VEC_ADDR     <= vec_d;
            O_CMP_VALID    <= analog_q && (settle_q == 8'h00);
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_FALL3: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R2
        (live && src3_q && !src3) |=> pend_q[3]) else $error("line0 fall not pending");
    AST_RISE3: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R2
        (!pend_q[3] && !I_PEND_WR && !src3_q && src3) |=> !pend_q[3])
        else $error("line0 rise set pending");
    AST_BOTH: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R13
        (live && edge_mode == 2'b11 && src2_q != src2) |=> pend_q[2])
        else $error("both edge missed");
    AST_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R17
        (pend_q[1] && !I_PEND_WR && !I_ACK[1]) |=> pend_q[1]) else $error("pending lost");
    AST_ACK: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R17
        (I_ACK[4] && !I_PEND_WR && !I_TIMER_ZERO_EV) |=> !pend_q[4]) else $error("ack ignored");
    AST_CMPOUT: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R5
        I_CONFIG_REG[0] |=> O_PORT3_OUT[0] == $past(cal_q)) else $error("cmp a not routed");
    AST_TIMER_ONE_OUTPUT: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R8
        1'b1 |=> O_PORT3_OUT[2] == $past(I_TIMER_ONE_OUT)) else $error("timer out wrong");
    AST_VEC: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R11
        (I_VEC_SEL == 3'd5) |=> O_VEC_ADDR == 12'd10) else $error("vector wrong");
    AST_ANA: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R14
        (live && analog && analog_q && edge_mode == 2'b00 && $past(cal_q) && !cal_q)
        |=> pend_q[2]) else $error("comparator a fall not on source 2");
    AST_ANB: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R14
        (live && analog && analog_q && edge_mode == 2'b00 && $past(cbl_q) && !cbl_q)
        |=> pend_q[0]) else $error("comparator b fall not on source 0");
    AST_SETTLE: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N) // R6
        $rose(analog) |=> !O_CMP_VALID [*8]) else $error("cmp valid too early");
    COV_BOTH: cover property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        edge_mode == 2'b11 && hit[0]);
    COV_ANALOG: cover property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        analog && hit[2]);
    COV_RACE: cover property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
        I_ACK[3] && hit[3]);
endmodule // p3irq_top
`default_nettype wire

// ---- rtl/p3irq_pkg.sv ----
/*
 * Constants for the port 3 interrupt source block: bit positions,
 * reset values, vector locations and the comparator settle time.
 * Assumes a single 125 MHz core clock and an active-low async reset.
 */
// Functional notes
// R1 - pending register bits 7:6 pick edge mode for lines 1 and 2
// R2 - lines 0 and 3 request only on a falling edge
// R3 - analog mode: lines 1,2 feed comparators, line 3 is reference
// R4 - digital mode: line 3 is a readable input and source 1
// R5 - config bit D0 set drives comparator results onto lines 4 and 7
// R6 - software waits two no-op times after enabling comparators
// R7 - software clears sources 0..2 pending when comparators toggle
// R8 - timer one input from line 1, timer one output onto line 6
// R9 - handshake lines for ports 0,1,2 live on lines 1 through 6; code takes inputs from lines 0..3, outputs on lines 4,5
// R10 - program addresses 12 to 4095 are ROM, below 12 vectors
// R11 - source n vectors through locations 2n and 2n+1
// R12 - line2 to source0, line3 source1, line1 source2, line0 source3
// R13 - edge field 00 FF, 01 F/R, 10 R/F, 11 both/both
// R14 - analog: comparator a to source 2, comparator b to source 0
// R15 - vector pair holds 16-bit service routine address
// R16 - mode register D1 selects analog comparator paths
// R17 - pending set on qualifying edge, held until cleared or acked
package p3irq_pkg;
    // ---------------------------------------------------------------
    // bit positions and reset values
    // ---------------------------------------------------------------
    localparam int          EDGE_HI_BIT    = 7;
    localparam int          EDGE_LO_BIT    = 6;
    localparam int          ANALOG_BIT     = 1;
    localparam int          CMP_OUT_BIT    = 0;
    localparam logic [7:0]  PEND_RST       = 8'h00;
    localparam int          NUM_SRC        = 6;
    // edge detection stays off this many clocks after reset
    localparam int          WARM_CYC       = 5;
    // ---------------------------------------------------------------
    // program memory map
    // ---------------------------------------------------------------
    localparam logic [11:0] ROM_FIRST_ADDR = 12'h00C;
    localparam logic [11:0] ROM_LAST_ADDR  = 12'hFFF;
    // ---------------------------------------------------------------
    // comparator settle: two no-op times, each 6 core clocks assumed
    // ---------------------------------------------------------------
    localparam int          SETTLE_NS      = 96;
    localparam int          CLK_PERIOD_NS  = 8;
    localparam int          SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- verif/p3irq_far_side.sv ----
/*
 * Far-side model of the pins and comparator front ends of port 3.
 * Assumes the bench sets digital levels and analog voltages.
 */
`timescale 1ns/100ps
`default_nettype none
module p3irq_far_side (
    input  wire logic [3:0] i_dig,   // digital levels, lines 0..3
    input  wire logic [7:0] i_va,    // line 1 voltage
    input  wire logic [7:0] i_vb,    // line 2 voltage
    input  wire logic [7:0] i_vref,  // line 3 voltage
    output logic      [3:0] o_pins,
    output logic            o_cmp_a,
    output logic            o_cmp_b
);
    // pins are fixed inputs: always driven, no release state
    assign o_pins  = i_dig;
    // both comparators share line 3 as their reference
    assign o_cmp_a = (i_va > i_vref);
    assign o_cmp_b = (i_vb > i_vref);
endmodule // p3irq_far_side
`default_nettype wire

// ---- verif/p3irq_top_test.sv ----
/*
 * Self-checking bench for the port 3 interrupt source block.
 * Assumes the design of p3irq_top and the far-side model.
 */
`timescale 1ns/100ps
`default_nettype none
module p3irq_top_test;
    typedef struct packed {
        logic [1:0] fld;
        logic [3:0] pin0;
        logic [3:0] pin1;
        logic [5:0] irq;
    } p3irq_row_t;
    // ------------------------------------------------------------
    // rows: edge field, start pins, end pins, expected flags
    // ------------------------------------------------------------
    localparam p3irq_row_t ROWS [11] = '{
        '{2'h0, 4'hF, 4'hE, 6'h08}, '{2'h0, 4'hF, 4'h7, 6'h02}, '{2'h0, 4'hF, 4'hD, 6'h04},
        '{2'h0, 4'hF, 4'hB, 6'h01}, '{2'h0, 4'h0, 4'hF, 6'h00}, '{2'h1, 4'hF, 4'h9, 6'h04},
        '{2'h1, 4'h0, 4'h6, 6'h01}, '{2'h2, 4'h0, 4'h6, 6'h04}, '{2'h2, 4'hF, 4'h9, 6'h01},
        '{2'h3, 4'hF, 4'h9, 6'h05}, '{2'h3, 4'h9, 4'hF, 6'h05}};
    logic        clk = 1'h0, arst_n = 1'h0, wr = 1'h0, ev0 = 1'h0, ev1 = 1'h0, t1o = 1'h0;
    logic [3:0]  dig = 4'hF, pins, rd, hs_in, p_out;
    logic [7:0]  va = 8'hC8, vb = 8'hC8, vref = 8'h64, mode = 8'h00, cfg = 8'h00;
    logic [7:0]  wdata = 8'h00, pend;
    logic [5:0]  ack = 6'h00, irq;
    logic [1:0]  hs = 2'h0;
    logic [2:0]  vsel = 3'h0;
    logic [11:0] vaddr;
    logic        cmp_a, cmp_b, t1_in, cvalid;
    int          fails = 0, checked = 0, cyc = 0;
    always #4 clk = ~clk;
    p3irq_far_side i_far (.i_dig(dig), .i_va(va), .i_vb(vb), .i_vref(vref), .o_pins(pins),
        .o_cmp_a(cmp_a), .o_cmp_b(cmp_b));
    p3irq_top i_dut (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_PORT3_IN(pins),
        .I_CMP_A_RESULT(cmp_a), .I_CMP_B_RESULT(cmp_b), .I_TIMER_ZERO_EV(ev0),
        .I_TIMER_ONE_EV(ev1), .I_TIMER_ONE_OUT(t1o), .I_HS_OUT(hs), .I_MODE_REG(mode),
        .I_CONFIG_REG(cfg), .I_PEND_WR(wr), .I_PEND_WDATA(wdata), .I_ACK(ack),
        .I_VEC_SEL(vsel), .O_PEND_REG(pend), .O_PORT3_RD(rd), .O_TIMER_ONE_IN(t1_in),
        .O_HS_IN(hs_in), .O_PORT3_OUT(p_out), .O_IRQ(irq), .O_VEC_ADDR(vaddr),
        .O_CMP_VALID(cvalid));
    // hang guard: whole run needs well under 1000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            $display("ERROR %0t run hung", $time);
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // step leaves us 1 ns past the edge so outputs have settled
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pend_write(input logic [7:0] v);
        @(posedge clk);
        wr <= 1'h1;
        wdata <= v;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask
    initial begin
        // ------------------------------------------------------------
        // reset, then table of edge cases
        // ------------------------------------------------------------
        step(6);
        chk(pend, 12'h000, "reset pending");
        arst_n <= 1'h1;
        step(8);
        for (int i = 0; i < 11; i++) begin
            dig <= ROWS[i].pin0;
            step(8);
            pend_write({ROWS[i].fld, 6'h00});
            dig <= ROWS[i].pin1;
            step(8);
            chk(irq, ROWS[i].irq, "edge row flags");
            chk(pend[7:6], ROWS[i].fld, "edge field");
            chk(rd, ROWS[i].pin1, "port read");
        end
        $display("test edge rows done");
        // internal timer sources, ack, set beats clear
        pend_write(8'h00);
        @(posedge clk);
        ev0 <= 1'h1;
        @(posedge clk);
        ev0 <= 1'h0;
        ack <= 6'h10;
        #1;
        chk(irq, 6'h10, "timer zero flag");
        step(1);
        chk(irq, 6'h00, "ack clears");
        ack <= 6'h00;
        ev1 <= 1'h1;
        wr <= 1'h1;
        step(1);
        ev1 <= 1'h0;
        wr <= 1'h0;
        chk(irq, 6'h20, "set over clear");
        $display("test timer sources done");
        // analog mode: wait settle, clear stale flags, then swing inputs
        mode <= 8'h02;
        step(2);
        chk(cvalid, 12'h000, "comparator not yet valid");
        step(p3irq_pkg::SETTLE_CYC);
        chk(cvalid, 12'h001, "comparator valid");
        pend_write(8'h00);
        va <= 8'h32;
        step(8);
        chk(irq, 6'h04, "comparator a source");
        pend_write(8'h00);
        vb <= 8'h32;
        step(8);
        chk(irq, 6'h01, "comparator b source");
        cfg <= 8'h01;
        va <= 8'hC8;
        step(8);
        chk({p_out[3], p_out[0]}, 12'h001, "comparator out pins");
        $display("test analog done");
        // digital mode, pin functions and output routing
        mode <= 8'h00;
        cfg <= 8'h00;
        hs <= 2'h2;
        t1o <= 1'h1;
        dig <= 4'hD;
        step(8);
        pend_write(8'h00);
        chk(p_out, 12'h006, "output pins");
        chk(t1_in, 12'h000, "timer one input");
        chk(hs_in, 12'h00E, "handshake inputs");
        for (int v = 0; v < 8; v++) begin
            @(posedge clk);
            vsel <= v[2:0];
            step(2);
            chk(vaddr, (v < 6) ? 12'(2 * v) : 12'h00C, "vector address");
        end
        $display("test pins and vectors done");
        // second reset in mid-run with a flag pending
        dig <= 4'hC;
        step(8);
        arst_n <= 1'h0;
        step(2);
        chk(irq, 12'h000, "mid-run reset");
        // lines 0 and 1 stay low through the release: no request may follow
        arst_n <= 1'h1;
        step(8);
        chk(irq, 12'h000, "no request from level held through reset");
        chk(rd, 12'h00C, "port read after reset");
        dig <= 4'h8;
        step(8);
        chk(irq, 12'h001, "first edge after reset");
        $display("test reset done");
        close_out();
    end
endmodule // p3irq_top_test
`default_nettype wire
